/* File: logic/phd_hub.sv */
// Overview of operation
// - cpu and dma both master the hub
// - arbiter serves highest priority pending channel, or the fairness-favoured level when fairness is on
// - eight spokes, spoke 0 sram, 5 reserved
// - cpu and dma overlap on different spokes
// - source and destination beats overlap across spokes
// - transfers of 8, 16, 24, 32 bits
// - 24 channels sharing 127 descriptors
// - descriptors writable while running
// - eight priority levels, zero most urgent
// - trigger by signal, cpu or channel done
// - two interrupts per channel transfer
// - transactions can be stalled or cancelled
// - length unlimited or 1 to 64k bytes
// - bursts of 1 to 127 bytes
// - descriptors chain to following descriptors
// - cpu wins shared spoke, dma never starved
// - preemption only at transaction boundary
// - levels 0, 1 outside fairness
// - levels 2..7 get halving bandwidth shares
// - equal level ties rotate round robin
// - per channel bit bypasses rotation
// - fairness off means pure priority
`timescale 1ns/100ps
`default_nettype none

module phd_hub #(
	parameter int NUM_CH = phd_pkg::NUM_CH,
	parameter int NUM_TD = phd_pkg::NUM_TD
) (
	input  wire logic                                  sys_clk,
	input  wire logic                                  rst,
	input  wire phd_pkg::phd_ch_cfg_t [NUM_CH-1:0]     chCfg,
	input  wire logic                                  fairEn,
	input  wire logic [NUM_CH-1:0]                     routeTrig,
	input  wire logic [NUM_CH-1:0]                     cpuTrig,
	input  wire logic [NUM_CH-1:0]                     chStall,
	input  wire logic [NUM_CH-1:0]                     chCancel,
	input  wire logic                                  tdWrEn,
	input  wire logic [6:0]                            tdWrIdx,
	input  wire phd_pkg::phd_td_t                      tdWrData,
	input  wire logic                                  cpuReq,
	input  wire logic [2:0]                            cpuSpoke,
	input  wire logic [31:0]                           dmaRdData,
	output logic                                       cpuGrant,
	output logic                                       cpuErr,
	output logic                                       dmaRdStb,
	output logic [2:0]                                 dmaRdSpoke,
	output logic [31:0]                                dmaRdAddr,
	output logic                                       dmaWrStb,
	output logic [2:0]                                 dmaWrSpoke,
	output logic [31:0]                                dmaWrAddr,
	output logic [31:0]                                dmaWrData,
	output phd_pkg::phd_width_t                        dmaSize,
	output logic                                       dmaBusy,
	output logic [$clog2(NUM_CH)-1:0]                  activeCh,
	output logic                                       dmaErr,
	output logic [NUM_CH-1:0]                          chIrqDone,
	output logic [NUM_CH-1:0]                          chIrqChain
);
	import phd_pkg::*;

	localparam int CH_W = $clog2(NUM_CH);

	// ****************************************
	// state
	// ****************************************
	phd_td_t             tdMem [NUM_TD];
	phd_td_t             td;
	phd_td_t             ldTd;
	phd_state_t          state;
	logic [CH_W-1:0]     actCh;
	logic [6:0]          tdIdx;
	logic [6:0]          curTd [NUM_CH];
	logic [NUM_CH-1:0]   pend;
	logic [NUM_CH-1:0]   trigVec;
	logic [NUM_CH-1:0]   cand;
	logic [CH_W-1:0]     rrPtr;
	logic [CH_W-1:0]     selCh;
	logic [2:0]          minLvl;
	logic [2:0]          selLvl;
	logic [7:0]          lvlReq;
	logic [5:0]          slotCnt;
	logic [16:0]         remLen;
	logic [6:0]          remBurst;
	logic [31:0]         rdAddr;
	logic [31:0]         wrAddr;
	logic [2:0]          starveCnt;
	logic [2:0]          beatBytes;
	logic                readsDone;
	logic                burstDone;
	logic                bufValid;
	logic                wantRd;
	logic                wantWr;
	logic                rdGo;
	logic                wrGo;
	logic                cpuGo;
	logic                starve;
	logic                lenLast;
	logic                burstLast;
	logic                ldErr;
	logic                endNow;
	logic                chainEnd;
	logic                cancelAct;
	logic                startNow;

	// round robin search from one past ptr; with ptr at the top it is a plain lowest-first
	function automatic logic [CH_W-1:0] rrPick(input logic [NUM_CH-1:0] mask,
		input logic [CH_W-1:0] ptr);
		int idx;
		rrPick = ptr;
		for (int i = NUM_CH; i >= 1; i--) begin
			idx = (int'(ptr) + i) % NUM_CH;
			if (mask[idx]) begin
				rrPick = CH_W'(idx);
			end
		end
	endfunction

	// ****************************************
	// channel arbitration
	// ****************************************
	// arbitration is only consulted from idle, so a running transaction is never cut
	always_comb begin
		logic [NUM_CH-1:0] lvlMask;
		logic [NUM_CH-1:0] headMask;
		int                tz;
		lvlMask  = '0;
		headMask = '0;
		tz       = 6;
		lvlReq   = '0;
		cand     = pend;
		for (int i = 0; i < NUM_CH; i++) begin
			cand[i] = pend[i] & chCfg[i].enable;
			if (cand[i]) begin
				lvlReq[chCfg[i].prio] = 1'b1;
			end
		end
		minLvl = LVL_LOWEST;
		for (int l = NUM_LVL - 1; l >= 0; l--) begin
			if (lvlReq[l]) begin
				minLvl = 3'(l);
			end
		end
		// lowest set bit of the slot counter picks the favoured level: 1/2, 1/4 ... 1/64
		for (int k = 5; k >= 0; k--) begin
			if (slotCnt[k]) begin
				tz = k;
			end
		end
		selLvl = minLvl;
		if (fairEn && minLvl >= LVL_FAIR_MIN && tz < 6) begin
			if (lvlReq[tz + 2]) begin
				selLvl = 3'(tz + 2);
			end
		end
		for (int i = 0; i < NUM_CH; i++) begin
			lvlMask[i]  = cand[i] && chCfg[i].prio == selLvl;
			headMask[i] = lvlMask[i] && chCfg[i].noRr;
		end
		if (headMask != '0) begin
			selCh = rrPick(headMask, CH_W'(NUM_CH - 1));
		end else begin
			selCh = rrPick(lvlMask, rrPtr);
		end
	end

	// ****************************************
	// beat scheduling on the spokes
	// ****************************************
	always_comb begin
		logic cpuOnSrc;
		logic cpuOnDst;
		cpuOnSrc  = cpuReq && cpuSpoke == td.srcSpoke;
		cpuOnDst  = cpuReq && cpuSpoke == td.dstSpoke;
		beatBytes = {1'b0, td.width} + 3'h1;
		starve    = starveCnt == STARVE_LIMIT;
		wantWr    = state == S_MOVE && bufValid && !chStall[actCh];
		wantRd    = state == S_MOVE && !readsDone && !burstDone && !chStall[actCh];
		// a reserved spoke never gets a grant; the cpu yields one cycle when dma starves
		cpuGo     = cpuReq && cpuSpoke != SPOKE_RSVD
			&& !(starve && ((cpuOnSrc && wantRd) || (cpuOnDst && wantWr)));
		wrGo      = wantWr && !(cpuGo && cpuOnDst);
		rdGo      = wantRd && (!bufValid || wrGo)
			&& !(cpuGo && cpuOnSrc)
			&& !(wrGo && td.dstSpoke == td.srcSpoke);
		lenLast   = td.length != LEN_UNLIMITED && remLen <= 17'(beatBytes);
		burstLast = remBurst <= 7'(beatBytes);
		ldTd      = (int'(tdIdx) < NUM_TD) ? tdMem[tdIdx] : '0;
		ldErr     = state == S_LOAD && (int'(tdIdx) >= NUM_TD
			|| ldTd.srcSpoke == SPOKE_RSVD || ldTd.dstSpoke == SPOKE_RSVD);
		cancelAct = state != S_IDLE && chCancel[actCh];
		endNow    = state == S_MOVE && readsDone && !bufValid;
		chainEnd  = endNow && td.nextTd == TD_END;
		startNow  = state == S_IDLE && cand != '0;
	end

	// ****************************************
	// triggers and pending flags
	// ****************************************
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			trigVec[i] = routeTrig[i] | cpuTrig[i]
				| (chCfg[i].chainEn && chIrqChainSrc(chCfg[i].chainSrc));
		end
	end

	function automatic logic chIrqChainSrc(input logic [4:0] src);
		chIrqChainSrc = chainEnd && actCh == CH_W'(src);
	endfunction

	// a trigger landing in the clearing cycle wins, so no request is lost
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (trigVec[i] && chCfg[i].enable) begin
					pend[i] <= 1'b1;
				end else if (chCancel[i] || (actCh == CH_W'(i) && (chainEnd || ldErr))) begin
					pend[i] <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// descriptor pool and channel positions
	// ****************************************
	// pool writes land at any time; a running transaction keeps its loaded copy
	always_ff @(posedge sys_clk) begin
		if (tdWrEn && int'(tdWrIdx) < NUM_TD) begin
			tdMem[tdWrIdx] <= tdWrData;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				curTd[i] <= TD_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (!chCfg[i].enable || chCancel[i]) begin
					curTd[i] <= chCfg[i].firstTd;
				end else if (actCh == CH_W'(i) && (chainEnd || ldErr)) begin
					curTd[i] <= chCfg[i].firstTd;
				end else if (actCh == CH_W'(i) && endNow) begin
					curTd[i] <= td.nextTd;
				end
			end
		end
	end

	// ****************************************
	// transaction engine
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state     <= S_IDLE;
			actCh     <= '0;
			tdIdx     <= TD_RESET;
			td        <= '0;
			remLen    <= LEN_UNLIMITED;
			remBurst  <= '0;
			rdAddr    <= ADDR_RESET;
			wrAddr    <= ADDR_RESET;
			readsDone <= 1'b0;
			burstDone <= 1'b0;
			bufValid  <= 1'b0;
			rrPtr     <= '0;
			slotCnt   <= SLOT_RESET;
		end else begin
			case (state)
				S_IDLE: begin
					if (startNow) begin
						actCh <= selCh;
						tdIdx <= curTd[selCh];
						rrPtr <= selCh;
						if (chCfg[selCh].prio >= LVL_FAIR_MIN) begin
							slotCnt <= slotCnt + 6'h01;
						end
						state <= S_LOAD;
					end
				end
				S_LOAD: begin
					td        <= ldTd;
					remLen    <= ldTd.length;
					remBurst  <= (ldTd.burst == '0) ? 7'h01 : ldTd.burst;
					rdAddr    <= ldTd.srcAddr;
					wrAddr    <= ldTd.dstAddr;
					readsDone <= 1'b0;
					burstDone <= 1'b0;
					bufValid  <= 1'b0;
					state     <= (ldErr || cancelAct) ? S_IDLE : S_MOVE;
				end
				S_MOVE: begin
					if (rdGo) begin
						rdAddr    <= rdAddr + 32'(beatBytes);
						remLen    <= remLen - 17'(beatBytes);
						remBurst  <= remBurst - 7'(beatBytes);
						readsDone <= lenLast;
						burstDone <= burstLast;
					end
					if (wrGo) begin
						wrAddr <= wrAddr + 32'(beatBytes);
					end
					bufValid <= rdGo || (bufValid && !wrGo);
					if (cancelAct || endNow) begin
						state <= S_IDLE;
					end else if (burstDone && !bufValid) begin
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					// the next burst of a transaction waits for the channel's next trigger
					if (cancelAct) begin
						state <= S_IDLE;
					end else if (trigVec[actCh]) begin
						remBurst  <= (td.burst == '0) ? 7'h01 : td.burst;
						burstDone <= 1'b0;
						state     <= S_MOVE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// stall counter: the cpu may hold a spoke only a bounded time against the dma
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			starveCnt <= '0;
		end else if (((wantRd && !rdGo) || (wantWr && !wrGo)) && cpuGo) begin
			starveCnt <= starve ? starveCnt : starveCnt + 3'h1;
		end else begin
			starveCnt <= '0;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpuGrant   <= 1'b0;
			cpuErr     <= 1'b0;
			dmaRdStb   <= 1'b0;
			dmaRdSpoke <= SPOKE_SRAM;
			dmaRdAddr  <= ADDR_RESET;
			dmaWrStb   <= 1'b0;
			dmaWrSpoke <= SPOKE_SRAM;
			dmaWrAddr  <= ADDR_RESET;
			dmaSize    <= W8;
			dmaBusy    <= 1'b0;
			activeCh   <= '0;
			dmaErr     <= 1'b0;
		end else begin
			cpuGrant   <= cpuGo;
			cpuErr     <= cpuReq && cpuSpoke == SPOKE_RSVD;
			dmaRdStb   <= rdGo;
			dmaRdSpoke <= td.srcSpoke;
			dmaRdAddr  <= rdAddr;
			dmaWrStb   <= wrGo;
			dmaWrSpoke <= td.dstSpoke;
			dmaWrAddr  <= wrAddr;
			dmaSize    <= td.width;
			dmaBusy    <= state != S_IDLE;
			activeCh   <= actCh;
			dmaErr     <= ldErr;
		end
	end

	// read data lands in the one-beat holding register that feeds the write side
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dmaWrData <= 32'h0000_0000;
		end else if (dmaRdStb) begin
			dmaWrData <= dmaRdData;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chIrqDone  <= '0;
			chIrqChain <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				chIrqDone[i]  <= endNow && actCh == CH_W'(i) && td.irqDone;
				chIrqChain[i] <= chainEnd && actCh == CH_W'(i) && td.irqChainEnd;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_cpu_first_grant: assert property (@(posedge sys_clk) disable iff (rst)
		(cpuReq && cpuSpoke != SPOKE_RSVD && !starve) |=> cpuGrant)
		else $error("cpu not granted first");
	a_rsvd_spoke_refused: assert property (@(posedge sys_clk) disable iff (rst)
		(cpuReq && cpuSpoke == SPOKE_RSVD) |=> (cpuErr && !cpuGrant))
		else $error("reserved spoke granted");
	a_spoke_one_master: assert property (@(posedge sys_clk) disable iff (rst)
		(cpuGo && (rdGo || wrGo)) |-> (cpuSpoke != (rdGo ? td.srcSpoke : td.dstSpoke)))
		else $error("two masters on one spoke");
	a_rd_wr_spokes: assert property (@(posedge sys_clk) disable iff (rst)
		(dmaRdStb && dmaWrStb) |-> (dmaRdSpoke != dmaWrSpoke))
		else $error("read and write on one spoke");
	a_dma_not_starved: assert property (@(posedge sys_clk) disable iff (rst)
		(starve && wantWr) |=> dmaWrStb)
		else $error("dma starved by cpu");
	a_owner_held: assert property (@(posedge sys_clk) disable iff (rst)
		(state != S_IDLE) |=> $stable(actCh))
		else $error("channel switched mid transaction");
	a_pure_priority: assert property (@(posedge sys_clk) disable iff (rst)
		(startNow && !fairEn) |=> (chCfg[actCh].prio == $past(minLvl)))
		else $error("non priority pick with fairness off");
	a_stall_holds: assert property (@(posedge sys_clk) disable iff (rst)
		(state == S_MOVE && chStall[actCh]) |=> !(dmaRdStb || dmaWrStb))
		else $error("beat moved while stalled");
	a_cancel_stops: assert property (@(posedge sys_clk) disable iff (rst)
		cancelAct |=> (state == S_IDLE) ##1 !dmaRdStb)
		else $error("cancel did not stop");

endmodule // phd_hub

`default_nettype wire

/* File: logic/phd_pkg.sv */
`default_nettype none

package phd_pkg;

	// ****************************************
	// hub geometry and channel pool
	// ****************************************
	localparam int NUM_CH    = 24;
	localparam int NUM_TD    = 127;
	localparam int NUM_SPOKE = 8;
	localparam int NUM_LVL   = 8;

	localparam logic [2:0]  SPOKE_SRAM    = 3'h0;
	localparam logic [2:0]  SPOKE_RSVD    = 3'h5;
	localparam logic [6:0]  TD_END        = 7'h7F;
	localparam logic [6:0]  TD_RESET      = 7'h00;
	localparam logic [16:0] LEN_UNLIMITED = 17'h0_0000;
	localparam logic [2:0]  LVL_FAIR_MIN  = 3'h2;
	localparam logic [2:0]  LVL_LOWEST    = 3'h7;
	localparam logic [5:0]  SLOT_RESET    = 6'h00;
	localparam logic [2:0]  STARVE_LIMIT  = 3'h4;
	localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		W8  = 2'h0,
		W16 = 2'h1,
		W24 = 2'h2,
		W32 = 2'h3
	} phd_width_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_LOAD = 4'h2,
		S_MOVE = 4'h4,
		S_WAIT = 4'h8
	} phd_state_t;

	typedef struct packed {
		logic [31:0] srcAddr;
		logic [31:0] dstAddr;
		logic [2:0]  srcSpoke;
		logic [2:0]  dstSpoke;
		logic [16:0] length;
		logic [6:0]  burst;
		phd_width_t  width;
		logic [6:0]  nextTd;
		logic        irqDone;
		logic        irqChainEnd;
	} phd_td_t;

	typedef struct packed {
		logic       enable;
		logic [2:0] prio;
		logic [6:0] firstTd;
		logic       noRr;
		logic       chainEn;
		logic [4:0] chainSrc;
	} phd_ch_cfg_t;

endpackage

`default_nettype wire

/* File: testbench/phd_spoke_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// peripherals on the spokes
// ****************************************
module phd_spoke_model (
	input  wire logic        sys_clk,
	input  wire logic        dmaRdStb,
	input  wire logic [31:0] dmaRdAddr,
	output logic      [31:0] dmaRdData
);
	logic [31:0] lastData;

	// read data is a fixed image of the address; off-beat the bus shows a changing pattern
	assign dmaRdData = dmaRdStb ? {dmaRdAddr[15:0], ~dmaRdAddr[15:0]} : ~lastData;

	// remember the last cycle's bus value so an idle bus shows its inverse, toggling every cycle
	always_ff @(posedge sys_clk) begin
		lastData <= dmaRdData;
	end
endmodule // phd_spoke_model

`default_nettype wire

/* File: testbench/tb_phd_hub.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_phd_hub;
	import phd_pkg::*;

	// ****************************************
	// stimulus and observation
	// ****************************************
	logic                     sys_clk = 1'b0;
	logic                     rst = 1'b1;
	phd_ch_cfg_t [NUM_CH-1:0] chCfg = '0;
	logic                     fairEn = 1'b0;
	logic [NUM_CH-1:0]        routeTrig = '0, cpuTrig = '0, chStall = '0, chCancel = '0;
	logic                     tdWrEn = 1'b0, cpuReq = 1'b0, clr = 1'b0, prevReq;
	logic [6:0]               tdWrIdx = 7'h00;
	phd_td_t                  tdWrData = '0;
	logic [2:0]               cpuSpoke = 3'h0, dmaRdSpoke, dmaWrSpoke;
	logic [31:0]              dmaRdData, dmaRdAddr, dmaWrAddr, dmaWrData;
	logic [31:0]              rdA0, wrA0, wrD0;
	logic [2:0]               rs0, ws0;
	logic                     cpuGrant, cpuErr, dmaRdStb, dmaWrStb, dmaBusy, dmaErr;
	phd_width_t               dmaSize, size0;
	logic [4:0]               activeCh, ch0;
	logic [NUM_CH-1:0]        chIrqDone, chIrqChain;
	int                       nRd, nWr, nDone, nChain, nErr, nMiss, errTotal, checked;
	logic [2:0]               sp [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};

	always #5 sys_clk = ~sys_clk;

	phd_hub i_phd_hub (.sys_clk(sys_clk), .rst(rst), .chCfg(chCfg), .fairEn(fairEn),
		.routeTrig(routeTrig), .cpuTrig(cpuTrig), .chStall(chStall), .chCancel(chCancel),
		.tdWrEn(tdWrEn), .tdWrIdx(tdWrIdx), .tdWrData(tdWrData), .cpuReq(cpuReq),
		.cpuSpoke(cpuSpoke), .dmaRdData(dmaRdData), .cpuGrant(cpuGrant), .cpuErr(cpuErr),
		.dmaRdStb(dmaRdStb), .dmaRdSpoke(dmaRdSpoke), .dmaRdAddr(dmaRdAddr),
		.dmaWrStb(dmaWrStb), .dmaWrSpoke(dmaWrSpoke), .dmaWrAddr(dmaWrAddr),
		.dmaWrData(dmaWrData), .dmaSize(dmaSize), .dmaBusy(dmaBusy), .activeCh(activeCh),
		.dmaErr(dmaErr), .chIrqDone(chIrqDone), .chIrqChain(chIrqChain));

	phd_spoke_model i_phd_spoke_model (.sys_clk(sys_clk), .dmaRdStb(dmaRdStb),
		.dmaRdAddr(dmaRdAddr), .dmaRdData(dmaRdData));

	// beat and pulse counters; the first beat of a run is kept for comparison
	always @(posedge sys_clk) begin
		prevReq <= cpuReq;
		if (clr) begin
			{nRd, nWr, nDone, nChain, nErr, nMiss} <= '0;
		end else begin
			if (dmaRdStb && nRd == 0) begin
				rdA0 <= dmaRdAddr;
				rs0  <= dmaRdSpoke;
				ch0  <= activeCh;
			end
			if (dmaWrStb && nWr == 0) begin
				ws0   <= dmaWrSpoke;
				wrA0  <= dmaWrAddr;
				wrD0  <= dmaWrData;
				size0 <= dmaSize;
			end
			nRd    <= nRd + dmaRdStb;
			nWr    <= nWr + dmaWrStb;
			nDone  <= nDone + $countones(chIrqDone);
			nChain <= nChain + $countones(chIrqChain);
			nErr   <= nErr + dmaErr;
			nMiss  <= nMiss + (prevReq && !cpuGrant);
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic finish_test;
		if (errTotal == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic phd_td_t mkTd(logic [2:0] s, logic [2:0] d, logic [31:0] a,
			logic [31:0] b, phd_width_t w, logic [16:0] len, logic [6:0] nxt);
		return '{srcAddr:a, dstAddr:b, srcSpoke:s, dstSpoke:d, length:len,
			burst:len[6:0], width:w, nextTd:nxt, irqDone:1'b1, irqChainEnd:1'b1};
	endfunction

	// the channel sits disabled for one edge so it picks up its first descriptor
	task automatic cfgCh(int ch, logic [2:0] p, logic [6:0] td, logic nr);
		@(posedge sys_clk);
		chCfg[ch] <= '{enable:1'b0, prio:p, firstTd:td, noRr:nr, chainEn:1'b0, chainSrc:5'h00};
		@(posedge sys_clk);
		chCfg[ch].enable <= 1'b1;
	endtask

	task automatic wrTd(logic [6:0] idx, phd_td_t td);
		@(posedge sys_clk);
		tdWrEn   <= 1'b1;
		tdWrIdx  <= idx;
		tdWrData <= td;
		@(posedge sys_clk);
		tdWrEn   <= 1'b0;
	endtask

	task automatic trig(logic [NUM_CH-1:0] m, logic route);
		@(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		if (route)
			routeTrig <= m;
		else
			cpuTrig <= m;
		@(posedge sys_clk);
		{routeTrig, cpuTrig} <= '0;
	endtask

	// bounded wait for a number of write beats, then let the pulses land
	task automatic waitWr(int n);
		for (int i = 0; i < 400 && nWr < n; i++)
			@(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic cpuOne(logic [2:0] s);
		@(posedge sys_clk);
		cpuReq   <= 1'b1;
		cpuSpoke <= s;
		@(posedge sys_clk);
		cpuReq   <= 1'b0;
		#1;
	endtask

	initial begin
		#200000;
		errTotal++;
		finish_test();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		logic [31:0] a, b, msk;
		logic [2:0]  s, d, p, q;
		int          k;
		phd_td_t     t;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		void'($urandom(32'h084b6f16));
		#1;
		check({cpuGrant, cpuErr, dmaRdStb, dmaWrStb, dmaBusy, dmaErr}, 32'h0000_0000);
		cpuOne(3'h3);
		check(cpuGrant, 1'b1);
		cpuOne(SPOKE_RSVD);
		check(cpuErr, 1'b1);
		// every width, random spokes and addresses, two chained descriptors each
		for (int w = 0; w < 4; w++) begin
			k   = $urandom % 6;
			s   = sp[k];
			d   = sp[(k + 1 + $urandom % 5) % 6];
			a   = $urandom & 32'hFFFF_FFFC;
			b   = $urandom & 32'hFFFF_FFFC;
			msk = 32'hFFFF_FFFF >> (8 * (3 - w));
			wrTd(7'(w), mkTd(s, d, a, b, phd_width_t'(w), 17'(2 * (w + 1)), 7'(w + 8)));
			wrTd(7'(w + 8), mkTd(d, s, b, a, phd_width_t'(w), 17'(2 * (w + 1)), TD_END));
			cfgCh(w, 3'(w), 7'(w), 1'b0);
			cpuReq   <= 1'b1;
			cpuSpoke <= SPOKE_SRAM;
			trig(NUM_CH'(1) << w, w[0]);
			waitWr(4);
			cpuReq <= 1'b0;
			check(nRd, 4);
			check(nWr, 4);
			check(rdA0, a);
			check(rs0, s);
			check(ws0, d);
			check(wrA0, b);
			check(wrD0 & msk, {a[15:0], ~a[15:0]} & msk);
			check(size0, w);
			check(nDone, 2);
			check(nChain, 1);
			check(nMiss, 0);
		end
		// pair of channels on distinct random levels, fairness off
		wrTd(7'h14, mkTd(3'h1, 3'h2, 32'h0000_1000, 32'h0000_2000, W32, 17'h0_0008, TD_END));
		wrTd(7'h15, mkTd(3'h3, 3'h4, 32'h0000_3000, 32'h0000_4000, W32, 17'h0_0008, TD_END));
		p = $urandom % 8;
		q = (p + 1 + $urandom % 7) % 8;
		cfgCh(5, p, 7'h14, 1'b0);
		cfgCh(6, q, 7'h15, 1'b0);
		trig(24'h00_0060, 1'b0);
		waitWr(4);
		check(ch0, (p < q) ? 5 : 6);
		check(nWr, 4);
		// equal level: rotation, then a bypass channel always first
		cfgCh(5, 3'h3, 7'h14, 1'b0);
		cfgCh(6, 3'h3, 7'h15, 1'b0);
		fairEn <= 1'b1;
		// a lone grant to 5 parks the pointer there, so the next tie must go to 6
		trig(24'h00_0020, 1'b1);
		waitWr(2);
		check(ch0, 5);
		trig(24'h00_0060, 1'b1);
		waitWr(4);
		check(ch0, 6);
		// pointer rests on 5 now, so only the bypass bit can put 5 first
		cfgCh(5, 3'h3, 7'h14, 1'b1);
		for (int r = 0; r < 2; r++) begin
			trig(24'h00_0060, 1'b1);
			waitWr(4);
			check(ch0, 5);
		end
		fairEn <= 1'b0;
		// descriptor pointing at the reserved spoke
		wrTd(7'h16, mkTd(SPOKE_RSVD, 3'h2, 32'h0000_0100, 32'h0000_0200, W8, 17'h0_0001, TD_END));
		cfgCh(7, 3'h0, 7'h16, 1'b0);
		trig(24'h00_0080, 1'b0);
		repeat (12) @(posedge sys_clk);
		check(nErr, 1);
		check(nRd, 0);
		// unlimited length stalled, then cancelled mid-burst
		// a long burst keeps beats flowing, so the stall has something to hold
		t       = mkTd(3'h1, 3'h2, 32'h0000_0400, 32'h0000_0800, W8, LEN_UNLIMITED, TD_END);
		t.burst = 7'h7F;
		wrTd(7'h17, t);
		cfgCh(8, 3'h2, 7'h17, 1'b0);
		trig(24'h00_0100, 1'b0);
		repeat (8) @(posedge sys_clk);
		chStall[8] <= 1'b1;
		repeat (2) @(posedge sys_clk);
		k = nRd;
		repeat (6) @(posedge sys_clk);
		check(nRd, k);
		chStall[8] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(nRd > k, 1'b1);
		chCancel[8] <= 1'b1;
		@(posedge sys_clk);
		chCancel[8] <= 1'b0;
		repeat (3) @(posedge sys_clk);
		k = nWr;
		repeat (20) @(posedge sys_clk);
		check(nWr, k);
		check(dmaBusy, 1'b0);
		// cpu camps on the source spoke; the transfer must still finish
		cpuReq   <= 1'b1;
		cpuSpoke <= 3'h1;
		trig(24'h00_0020, 1'b0);
		waitWr(2);
		cpuReq <= 1'b0;
		check(nWr, 2);
		check(nMiss > 0, 1'b1);
		// completion of channel 5 alone has to start channel 9
		cfgCh(9, 3'h4, 7'h15, 1'b0);
		@(posedge sys_clk);
		chCfg[9].chainEn  <= 1'b1;
		chCfg[9].chainSrc <= 5'h05;
		trig(24'h00_0020, 1'b0);
		waitWr(4);
		check(nRd, 4);
		check(nChain, 2);
		finish_test();
	end
endmodule // tb_phd_hub

`default_nettype wire
